// file: hw/mqp_pkg.sv
// Shared constants and carrier types of the MIDI word port and run control block
package mqp_pkg;

  localparam logic [31:0] MQP_ADDR_GEN_RUN  = 32'hC8000000;
  localparam logic [31:0] MQP_ADDR_IRQ_EN   = 32'hCF0001E8;
  localparam logic [31:0] MQP_ADDR_RX_PORT  = 32'hCF0001EC;
  localparam logic [31:0] MQP_ADDR_TX0_PORT = 32'hCF0001F0;
  localparam logic [31:0] MQP_ADDR_TX1_PORT = 32'hCF0001F4;
  localparam logic [31:0] MQP_ADDR_IRQ_STAT = 32'hCF0001F8;

  localparam logic [31:0] MQP_RESET_WORD    = 32'h00000000;
  localparam logic [2:0]  MQP_RESET_BITS3   = 3'h0;

  localparam int          MQP_BIT_FIRST_TX  = 0;
  localparam int          MQP_BIT_SECOND_TX = 1;
  localparam int          MQP_BIT_RX        = 2;

  localparam int          MQP_NUM_RX_MACH   = 4;
  localparam int          MQP_NUM_TX        = 2;
  localparam int          MQP_NUM_BUF       = 3;
  localparam int          MQP_BUF_RX        = 0;
  localparam int          MQP_BUF_TX0       = 1;
  localparam int          MQP_BUF_TX1       = 2;

  localparam int          MQP_PTR_W         = 4;
  localparam int          MQP_CNT_W         = 5;
  localparam logic [4:0]  MQP_BUF_DEPTH     = 5'h10;
  localparam logic [4:0]  MQP_CNT_ONE       = 5'h01;
  localparam logic [3:0]  MQP_PTR_ONE       = 4'h1;

  // One 32-bit MIDI word as carried on the ports and in the buffers
  typedef struct packed {
    logic [2:0] port_map;
    logic [1:0] source;
    logic       zero;
    logic [1:0] count;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } mqp_word_s;

  // What one receive machine hands over
  typedef struct packed {
    logic [2:0] port_map;
    logic [1:0] count;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } mqp_rx_in_s;

  typedef struct packed {
    logic irx_run;
    logic itx_run;
    logic avs_run;
  } mqp_run_s;

endpackage : mqp_pkg

// file: hw/mqp_word_mem.sv
// Buffer storage with write-first registered read port
`timescale 1ns/1ps
module mqp_word_mem
  import mqp_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 wr_en,
  input  wire logic [MQP_PTR_W-1:0] wr_addr,
  input  wire mqp_word_s            wr_data,
  input  wire logic [MQP_PTR_W-1:0] rd_addr,
  output mqp_word_s                 rd_data
);

  mqp_word_s mem_reg [2**MQP_PTR_W];
  mqp_word_s rd_data_reg;
  mqp_word_s rd_data_next;

  always_comb begin
    // Bypass so a word written to the head slot is visible at once
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_next = wr_data;
    end else begin
      rd_data_next = mem_reg[rd_addr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= MQP_RESET_WORD;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule : mqp_word_mem

// file: hw/mqp_midi_port.sv
// MIDI word port registers, word buffers and stream run control
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module mqp_midi_port
  import mqp_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic [31:0]                  reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [31:0]                       reg_rdata,
  input  wire logic [MQP_NUM_RX_MACH-1:0]   rx_valid,
  input  wire mqp_rx_in_s [MQP_NUM_RX_MACH-1:0] rx_in,
  output logic [MQP_NUM_RX_MACH-1:0]        rx_ready,
  output logic [MQP_NUM_TX-1:0]             tx_valid,
  output mqp_word_s [MQP_NUM_TX-1:0]        tx_word,
  input  wire logic [MQP_NUM_TX-1:0]        tx_ready,
  output mqp_run_s                          run_ctrl,
  output logic                              irq
);

  mqp_run_s                   run_reg;
  mqp_run_s                   run_next;
  logic [2:0]                 irq_en_reg;
  logic [2:0]                 irq_en_next;
  logic [2:0]                 irq_stat_reg;
  logic [2:0]                 irq_stat_next;
  logic [31:0]                rdata_reg;
  logic [31:0]                rdata_next;

  logic [MQP_NUM_BUF-1:0]     buf_push;
  logic [MQP_NUM_BUF-1:0]     buf_pop;
  logic [MQP_NUM_BUF-1:0]     buf_empty;
  logic [MQP_NUM_BUF-1:0]     buf_full;
  logic [MQP_NUM_BUF-1:0]     buf_drained;
  mqp_word_s [MQP_NUM_BUF-1:0] buf_din;
  mqp_word_s [MQP_NUM_BUF-1:0] buf_head;

  mqp_word_s                  rx_word;
  logic [MQP_NUM_RX_MACH-1:0] rx_grant;
  logic                       rx_open;
  logic                       tx_open;

  logic                       hit_gen;
  logic                       hit_en;
  logic                       hit_rx;
  logic                       hit_tx0;
  logic                       hit_tx1;
  logic                       hit_stat;

  assign hit_gen  = (reg_addr == MQP_ADDR_GEN_RUN);
  assign hit_en   = (reg_addr == MQP_ADDR_IRQ_EN);
  assign hit_rx   = (reg_addr == MQP_ADDR_RX_PORT);
  assign hit_tx0  = (reg_addr == MQP_ADDR_TX0_PORT);
  assign hit_tx1  = (reg_addr == MQP_ADDR_TX1_PORT);
  assign hit_stat = (reg_addr == MQP_ADDR_IRQ_STAT);

  // Receivers and transmitters only move words while their side runs
  assign rx_open = run_reg.avs_run & run_reg.irx_run;
  assign tx_open = run_reg.avs_run & run_reg.itx_run;

  // Fixed priority among the receive machines, lowest index first
  always_comb begin
    rx_grant = '0;
    rx_word  = MQP_RESET_WORD;
    if (rx_open && !buf_full[MQP_BUF_RX]) begin
      for (int m = MQP_NUM_RX_MACH - 1; m >= 0; m--) begin
        if (rx_valid[m]) begin
          rx_grant = '0;
          rx_grant[m] = 1'b1;
          rx_word.port_map = rx_in[m].port_map;
          rx_word.source   = 2'(m);
          rx_word.zero     = 1'b0;
          rx_word.count    = rx_in[m].count;
          rx_word.byte1    = rx_in[m].byte1;
          rx_word.byte2    = rx_in[m].byte2;
          rx_word.byte3    = rx_in[m].byte3;
        end
      end
    end
  end

  assign rx_ready = rx_grant;

  // Buffer traffic: receive fed by machines, drained by port reads
  always_comb begin
    buf_push             = '0;
    buf_pop              = '0;
    buf_din              = '0;
    buf_push[MQP_BUF_RX] = |rx_grant;
    buf_din[MQP_BUF_RX]  = rx_word;
    buf_pop[MQP_BUF_RX]  = reg_rd & hit_rx & ~buf_empty[MQP_BUF_RX];
    // A write to a full transmit buffer is dropped
    buf_push[MQP_BUF_TX0] = reg_wr & hit_tx0 & ~buf_full[MQP_BUF_TX0];
    buf_push[MQP_BUF_TX1] = reg_wr & hit_tx1 & ~buf_full[MQP_BUF_TX1];
    buf_din[MQP_BUF_TX0]  = reg_wdata;
    buf_din[MQP_BUF_TX1]  = reg_wdata;
    buf_pop[MQP_BUF_TX0]  = tx_valid[0] & tx_ready[0];
    buf_pop[MQP_BUF_TX1]  = tx_valid[1] & tx_ready[1];
  end

  // One shared receive buffer and one buffer per transmitter
  for (genvar g = 0; g < MQP_NUM_BUF; g++) begin : gen_buf
    logic [MQP_PTR_W-1:0] wr_ptr_reg;
    logic [MQP_PTR_W-1:0] wr_ptr_next;
    logic [MQP_PTR_W-1:0] rd_ptr_reg;
    logic [MQP_PTR_W-1:0] rd_ptr_next;
    logic [MQP_CNT_W-1:0] cnt_reg;
    logic [MQP_CNT_W-1:0] cnt_next;

    always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      cnt_next    = cnt_reg;
      if (buf_push[g]) begin
        wr_ptr_next = wr_ptr_reg + MQP_PTR_ONE;
      end
      if (buf_pop[g]) begin
        rd_ptr_next = rd_ptr_reg + MQP_PTR_ONE;
      end
      if (buf_push[g] && !buf_pop[g]) begin
        cnt_next = cnt_reg + MQP_CNT_ONE;
      end else if (!buf_push[g] && buf_pop[g]) begin
        cnt_next = cnt_reg - MQP_CNT_ONE;
      end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        cnt_reg    <= '0;
      end else begin
        wr_ptr_reg <= wr_ptr_next;
        rd_ptr_reg <= rd_ptr_next;
        cnt_reg    <= cnt_next;
      end
    end

    assign buf_empty[g]   = (cnt_reg == '0);
    assign buf_full[g]    = (cnt_reg == MQP_BUF_DEPTH);
    assign buf_drained[g] = buf_pop[g] & ~buf_push[g] & (cnt_reg == MQP_CNT_ONE);

    // Head word is prefetched so the port answers in one cycle
    mqp_word_mem u_mem (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .wr_en   (buf_push[g]),
      .wr_addr (wr_ptr_reg),
      .wr_data (buf_din[g]),
      .rd_addr (rd_ptr_next),
      .rd_data (buf_head[g])
    );
  end

  assign tx_valid[0] = tx_open & ~buf_empty[MQP_BUF_TX0];
  assign tx_valid[1] = tx_open & ~buf_empty[MQP_BUF_TX1];
  assign tx_word[0]  = buf_head[MQP_BUF_TX0];
  assign tx_word[1]  = buf_head[MQP_BUF_TX1];

  // Register writes, interrupt flags and read data
  always_comb begin
    run_next      = run_reg;
    irq_en_next   = irq_en_reg;
    irq_stat_next = irq_stat_reg;
    rdata_next    = MQP_RESET_WORD;

    if (reg_wr && hit_gen) begin
      run_next.avs_run = reg_wdata[0];
      run_next.itx_run = reg_wdata[1];
      run_next.irx_run = reg_wdata[2];
    end
    if (reg_wr && hit_en) begin
      irq_en_next = reg_wdata[2:0];
    end
    if (reg_wr && hit_stat) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[2:0];
    end
    // New events are set after the clear so they are never lost
    if (buf_push[MQP_BUF_RX]) begin
      irq_stat_next[MQP_BIT_RX] = 1'b1;
    end
    if (buf_drained[MQP_BUF_TX0]) begin
      irq_stat_next[MQP_BIT_FIRST_TX] = 1'b1;
    end
    if (buf_drained[MQP_BUF_TX1]) begin
      irq_stat_next[MQP_BIT_SECOND_TX] = 1'b1;
    end

    // Transmit ports read as zero; receive port writes are ignored
    if (reg_rd) begin
      unique case (1'b1)
        hit_gen:  rdata_next = {29'h00000000, run_reg.irx_run, run_reg.itx_run, run_reg.avs_run};
        hit_en:   rdata_next = {29'h00000000, irq_en_reg};
        hit_stat: rdata_next = {29'h00000000, irq_stat_reg};
        hit_rx: begin
          if (!buf_empty[MQP_BUF_RX]) begin
            rdata_next = buf_head[MQP_BUF_RX];
          end
        end
        default:  rdata_next = MQP_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg      <= MQP_RESET_BITS3;
      irq_en_reg   <= MQP_RESET_BITS3;
      irq_stat_reg <= MQP_RESET_BITS3;
      rdata_reg    <= MQP_RESET_WORD;
    end else begin
      run_reg      <= run_next;
      irq_en_reg   <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign run_ctrl  = run_reg;
  assign irq       = |(irq_stat_reg & irq_en_reg);

endmodule : mqp_midi_port

// file: testbench/mqp_midi_port_properties.sv
// Assertion checker for the MIDI word port block
`timescale 1ns/1ps
module mqp_midi_port_properties
  import mqp_pkg::*;
(
  input wire logic                             sys_clk,
  input wire logic                             reset_n,
  input wire logic [31:0]                      reg_addr,
  input wire logic [31:0]                      reg_wdata,
  input wire logic                             reg_wr,
  input wire logic                             reg_rd,
  input wire logic [31:0]                      reg_rdata,
  input wire logic [MQP_NUM_RX_MACH-1:0]       rx_valid,
  input wire mqp_rx_in_s [MQP_NUM_RX_MACH-1:0] rx_in,
  input wire logic [MQP_NUM_RX_MACH-1:0]       rx_ready,
  input wire logic [MQP_NUM_TX-1:0]            tx_valid,
  input wire mqp_word_s [MQP_NUM_TX-1:0]       tx_word,
  input wire logic [MQP_NUM_TX-1:0]            tx_ready,
  input wire mqp_run_s                         run_ctrl,
  input wire logic                             irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  rx_zero_a: assert property (reg_rd && reg_addr == MQP_ADDR_RX_PORT |=> !reg_rdata[26])
    else $error("receive word bit 26 set");
  tx_noread_a: assert property (reg_rd && reg_addr[31:3] == MQP_ADDR_TX0_PORT[31:3] |=> reg_rdata == 32'h0)
    else $error("transmit port readable");
  run_write_a: assert property (reg_wr && reg_addr == MQP_ADDR_GEN_RUN |=> run_ctrl == $past(reg_wdata[2:0]))
    else $error("run bits not written");
  rx_gate_a: assert property (rx_ready != 4'h0 |-> run_ctrl.avs_run && run_ctrl.irx_run)
    else $error("receive accepted while stopped");
  tx_gate_a: assert property (tx_valid != 2'h0 |-> run_ctrl.avs_run && run_ctrl.itx_run)
    else $error("transmit offered while stopped");
  rx_grant_a: assert property ($onehot0(rx_ready) && (rx_ready & ~rx_valid) == 4'h0)
    else $error("bad receive grant");
  rx_prio_a: assert property (rx_ready != 4'h0 |-> (rx_valid & (rx_ready - 4'h1)) == 4'h0)
    else $error("lower machine passed over");
  tx_hold_a: assert property (tx_valid[0] && !tx_ready[0] && !reg_wr |=> tx_valid[0] && $stable(tx_word[0]))
    else $error("transmit head lost");
  irq_mask_a: assert property (reg_wr && reg_addr == MQP_ADDR_IRQ_EN && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt with all enables off");
endmodule : mqp_midi_port_properties

bind mqp_midi_port mqp_midi_port_properties chk (.*);

// file: testbench/mqp_stream_model.sv
// Behavioural receive machines and transmitters facing the port block
`timescale 1ns/1ps
module mqp_stream_model
  import mqp_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            tx_stall,
  output logic [3:0]           rx_valid,
  output mqp_rx_in_s [3:0]     rx_in,
  input  wire logic [3:0]      rx_ready,
  input  wire logic [1:0]      tx_valid,
  input  wire mqp_word_s [1:0] tx_word,
  output logic [1:0]           tx_ready
);
  mqp_rx_in_s pend[4][$];
  mqp_word_s  got[2][$];
  initial rx_valid = 4'h0;
  initial rx_in = '0;
  assign tx_ready = tx_stall ? 2'h0 : 2'h3;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (tx_valid[i] && tx_ready[i]) got[i].push_back(tx_word[i]);
    end
    for (int m = 0; m < 4; m++) begin
      if (rx_valid[m] && rx_ready[m]) void'(pend[m].pop_front());
      rx_valid[m] <= pend[m].size() != 0;
      // Idle payload toggles so a stale word never looks valid
      rx_in[m] <= pend[m].size() != 0 ? pend[m][0] : ~rx_in[m];
    end
  end
endmodule : mqp_stream_model

// file: testbench/tb_top.sv
// Self-checking bench for the MIDI word port block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_top
  import mqp_pkg::*;
;
  typedef struct {bit w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} mqp_row_s;
  localparam logic [31:0] TXW0 = 32'hA3914567;
  localparam logic [31:0] TXW1 = 32'h62C0FF01;
  logic             sys_clk, reset_n, reg_wr, reg_rd, tx_stall, irq;
  logic [31:0]      reg_addr, reg_wdata, reg_rdata;
  logic [3:0]       rx_valid, rx_ready;
  mqp_rx_in_s [3:0] rx_in;
  logic [1:0]       tx_valid, tx_ready;
  mqp_word_s [1:0]  tx_word;
  mqp_run_s         run_ctrl;
  int               n_mismatch, cmp_count;
  mqp_row_s         rows [8] = '{
    '{1'b0, MQP_ADDR_IRQ_EN, 32'h0, 32'h0}, '{1'b0, MQP_ADDR_GEN_RUN, 32'h0, 32'h0},
    '{1'b0, MQP_ADDR_RX_PORT, 32'h0, 32'h0}, '{1'b1, MQP_ADDR_IRQ_EN, 32'hFFFFFFFF, 32'h7},
    '{1'b1, MQP_ADDR_GEN_RUN, 32'hFFFFFFFF, 32'h7}, '{1'b1, MQP_ADDR_RX_PORT, 32'h12345678, 32'h0},
    '{1'b1, 32'hCF0001E4, 32'h5A5A5A5A, 32'h0}, '{1'b1, MQP_ADDR_IRQ_EN, 32'h0, 32'h0}};

  mqp_midi_port dut (.*);
  mqp_stream_model mdl (.*);

  function automatic mqp_rx_in_s rxw(int m);
    return {3'(m + 2), 2'(m), 8'(8'hA0 + m), 8'h5C, 8'(8'h30 + m)};
  endfunction : rxw
  function automatic logic [31:0] rx_exp(int m);
    mqp_rx_in_s v = rxw(m);
    return {v.port_map, 2'(m), 1'b0, v.count, v.byte1, v.byte2, v.byte3};
  endfunction : rx_exp
  task automatic bus(input logic w, r, input logic [31:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [31:0] a, e);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, tx_stall} = 4'h0;
    {reg_addr, reg_wdata} = 64'h0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      if (rows[i].w) bus(1'b1, 1'b0, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("register table test done");
    // Machines 3 and 1 offer together; the lower index goes first
    mdl.pend[3].push_back(rxw(3));
    mdl.pend[1].push_back(rxw(1));
    for (int k = 0; k < 20 && mdl.pend[1].size() + mdl.pend[3].size() != 0; k++) @(posedge sys_clk);
    rd(MQP_ADDR_IRQ_STAT, 32'h4);
    `CHK(irq, 1'b0)
    rd(MQP_ADDR_RX_PORT, rx_exp(1));
    rd(MQP_ADDR_RX_PORT, rx_exp(3));
    rd(MQP_ADDR_RX_PORT, 32'h0);
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_EN, 32'h4);
    rd(MQP_ADDR_IRQ_EN, 32'h4);
    `CHK(irq, 1'b1)
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_STAT, 32'h4);
    rd(MQP_ADDR_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    $display("receive test done");
    tx_stall <= 1'b1;
    bus(1'b1, 1'b0, MQP_ADDR_TX0_PORT, TXW0);
    bus(1'b1, 1'b0, MQP_ADDR_TX1_PORT, TXW1);
    rd(MQP_ADDR_TX1_PORT, 32'h0);
    `CHK(tx_valid, 2'h3)
    tx_stall <= 1'b0;
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_EN, 32'h3);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    for (int k = 0; k < 20 && mdl.got[1].size() == 0; k++) @(posedge sys_clk);
    rd(MQP_ADDR_IRQ_STAT, 32'h3);
    `CHK(mdl.got[0][0], TXW0)
    `CHK(mdl.got[1][0], TXW1)
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_STAT, 32'h1);
    rd(MQP_ADDR_IRQ_STAT, 32'h2);
    `CHK(irq, 1'b1)
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_EN, 32'h0);
    rd(MQP_ADDR_IRQ_EN, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, 1'b0, MQP_ADDR_GEN_RUN, 32'h5);
    bus(1'b1, 1'b0, MQP_ADDR_TX0_PORT, TXW1);
    rd(MQP_ADDR_GEN_RUN, 32'h5);
    `CHK(run_ctrl, 3'h5)
    `CHK(tx_valid, 2'h0)
    `CHK(mdl.got[0].size(), 1)
    $display("transmit test done");
    // A machine offers while receive or the whole subsystem is stopped
    bus(1'b1, 1'b0, MQP_ADDR_GEN_RUN, 32'h3);
    mdl.pend[0].push_back(rxw(0));
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd(MQP_ADDR_RX_PORT, 32'h0);
    bus(1'b1, 1'b0, MQP_ADDR_GEN_RUN, 32'h6);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd(MQP_ADDR_RX_PORT, 32'h0);
    bus(1'b1, 1'b0, MQP_ADDR_GEN_RUN, 32'h7);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd(MQP_ADDR_RX_PORT, rx_exp(0));
    $display("run gate test done");
    // Reset in mid-run with a word waiting and an interrupt pending
    bus(1'b1, 1'b0, MQP_ADDR_IRQ_EN, 32'h7);
    mdl.pend[2].push_back(rxw(2));
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    `CHK(irq, 1'b0)
    `CHK(run_ctrl, 3'h0)
    rd(MQP_ADDR_IRQ_EN, 32'h0);
    rd(MQP_ADDR_RX_PORT, 32'h0);
    $display("mid-run reset test done");
    test_done();
  end
endmodule : tb_top
